// ---- hdl/asc_curve.sv ----
`default_nettype none
module asc_curve (
    input wire logic [6:0] step,
    input wire logic use_cplx,
    input wire logic steam_cap,
    input wire asc_pkg::asc_basic_t basic,
    input wire asc_pkg::asc_cplx_t cplx,
    output logic [7:0] level
);
    import asc_pkg::*;

    function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b,
                                        input logic [5:0] f);
        logic signed [15:0] sa;
        logic signed [15:0] sb;
        logic signed [15:0] sf;
        logic signed [15:0] d;
        sa = $signed({8'h00, a});
        sb = $signed({8'h00, b});
        sf = $signed({10'h000, f});
        d = (sb - sa) * sf;
        return 8'(sa + (d >>> 6));
    endfunction

    logic [13:0] prod;
    logic [4:0] idx;
    logic [7:0] bas;
    logic [7:0] cx;

    always_comb begin
        // 128 steps spread over 27 points; step 127 lands on the last one
        prod = {7'h00, step} * 14'h001B;
        idx = prod[11:7];
        cx = cplx[idx];
        if (step <= STEP_MID) begin
            bas = lerp(basic.vstart, basic.vmid, 6'(step - 7'h01));
        end else if (step == STEP_MAX) begin
            bas = basic.vhigh;
        end else begin
            bas = lerp(basic.vmid, basic.vhigh, 6'(step - STEP_MID));
        end
        if (step == 7'h00) begin
            level = 8'h00;
        end else if (!use_cplx) begin
            level = bas;
        end else if (steam_cap && (cx > basic.vhigh)) begin
            level = basic.vhigh;
        end else begin
            level = cx;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/asc_tick.sv ----
`default_nettype none
module asc_tick #(
    parameter int unsigned PERIOD = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    output logic tick
);
    import asc_pkg::*;
    localparam int unsigned W = $clog2(PERIOD + 1);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // Restarts from zero whenever run drops, so a new phase gets a full period
    always_comb begin
        nxt_cnt = cnt_ff;
        tick = 1'b0;
        if (!run) begin
            nxt_cnt = '0;
        end else if (cnt_ff == W'(PERIOD - 1)) begin
            nxt_cnt = '0;
            tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/asc_top.sv ----
`default_nettype none
module asc_top #(
    parameter bit PISTON_SYNC = 1'b0,
    parameter bit STEAM_CAP = 1'b0,
    parameter int unsigned HOLD_TICK_CYCLES = asc_pkg::HOLD_TICK_CYC,
    parameter int unsigned DECEL_CYCLES = asc_pkg::DECEL_STEP_CYC,
    parameter int unsigned DIST_CYCLES = asc_pkg::DIST_TICK_CYC
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire asc_pkg::asc_cmd_t THR_CMD,
    input wire logic ASYM_TRACK_CONDITION,
    input wire logic PICKUPS_CLEAR,
    output logic [7:0] MOTOR_DRIVE,
    output logic MOTOR_DIR,
    output logic BEMF_ENABLE,
    output logic HALTED
);
    import asc_pkg::*;

    logic [7:0] hold_ff, nxt_hold, bdist_ff, nxt_bdist, cfg_ff, nxt_cfg;
    logic [7:0] bemf_ff, nxt_bemf;
    logic [1:0] act_ff, nxt_act;
    asc_basic_t basic_ff, nxt_basic;
    asc_cplx_t cplx_ff, nxt_cplx;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wr_go, rd_go, w_cx, r_cx;
    logic [7:0] wa, ra;
    logic [4:0] w_idx, r_idx;
    asc_state_t st_ff, nxt_st;
    logic [6:0] thr_ff, nxt_thr;
    logic dir_ff, nxt_dir, bemf_en_ff, nxt_bemf_en;
    logic [7:0] drive_ff, nxt_drive, sec_ff, nxt_sec, curve_lvl;
    logic [15:0] dist_ff, nxt_dist, dist_tgt;
    logic asym_m_ff, asym_s_ff, asym_d_ff, pick_m_ff, pick_s_ff;
    logic sec_tick, dec_tick, dist_tick, asym_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus: write and address taken together, one response per channel at a time
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
    assign rd_go = S_AXI_ARVALID && !rvalid_ff;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign wa = {S_AXI_AWADDR[7:2], 2'b00};
    assign ra = {S_AXI_ARADDR[7:2], 2'b00};
    assign w_cx = (wa >= OFS_CPLX) && (wa < OFS_CPLX_END);
    assign r_cx = (ra >= OFS_CPLX) && (ra < OFS_CPLX_END);
    assign w_idx = 5'((wa - OFS_CPLX) >> 2);
    assign r_idx = 5'((ra - OFS_CPLX) >> 2);

    always_comb begin
        nxt_hold = hold_ff;
        nxt_bdist = bdist_ff;
        nxt_cfg = cfg_ff;
        nxt_bemf = bemf_ff;
        nxt_act = act_ff;
        nxt_basic = basic_ff;
        nxt_cplx = cplx_ff;
        nxt_bvalid = bvalid_ff && !S_AXI_BREADY;
        nxt_bresp = bresp_ff;
        if (wr_go) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            // Only byte lane 0 carries register data; other lanes are dropped
            if (w_cx) begin
                if (S_AXI_WSTRB[0]) nxt_cplx[w_idx] = S_AXI_WDATA[7:0];
            end else begin
                unique case (wa)
                    OFS_STOP_HOLD: if (S_AXI_WSTRB[0]) nxt_hold = S_AXI_WDATA[7:0];
                    OFS_BRAKE_DIST: if (S_AXI_WSTRB[0]) nxt_bdist = S_AXI_WDATA[7:0];
                    OFS_CONFIG: if (S_AXI_WSTRB[0]) nxt_cfg = S_AXI_WDATA[7:0];
                    OFS_BEMF: if (S_AXI_WSTRB[0]) nxt_bemf = S_AXI_WDATA[7:0];
                    OFS_ACTION: if (S_AXI_WSTRB[0]) nxt_act = S_AXI_WDATA[1:0];
                    OFS_VSTART: if (S_AXI_WSTRB[0]) nxt_basic.vstart = S_AXI_WDATA[7:0];
                    OFS_VMID: if (S_AXI_WSTRB[0]) nxt_basic.vmid = S_AXI_WDATA[7:0];
                    OFS_VHIGH: if (S_AXI_WSTRB[0]) nxt_basic.vhigh = S_AXI_WDATA[7:0];
                    OFS_STATUS: nxt_bresp = RESP_OKAY;
                    default: nxt_bresp = RESP_SLVERR;
                endcase
            end
        end
        nxt_rvalid = rvalid_ff && !S_AXI_RREADY;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (rd_go) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (r_cx) begin
                nxt_rdata[7:0] = cplx_ff[r_idx];
            end else begin
                unique case (ra)
                    OFS_STOP_HOLD: nxt_rdata[7:0] = hold_ff;
                    OFS_BRAKE_DIST: nxt_rdata[7:0] = bdist_ff;
                    OFS_CONFIG: nxt_rdata[7:0] = cfg_ff;
                    OFS_BEMF: nxt_rdata[7:0] = bemf_ff;
                    OFS_ACTION: nxt_rdata[1:0] = act_ff;
                    OFS_VSTART: nxt_rdata[7:0] = basic_ff.vstart;
                    OFS_VMID: nxt_rdata[7:0] = basic_ff.vmid;
                    OFS_VHIGH: nxt_rdata[7:0] = basic_ff.vhigh;
                    OFS_STATUS: begin
                        nxt_rdata[STAT_HALT_BIT] = (st_ff == ST_HOLD);
                        nxt_rdata[STAT_BRAKE_BIT] = (st_ff == ST_BRAKE);
                        nxt_rdata[STAT_BEMF_BIT] = bemf_en_ff;
                        nxt_rdata[STAT_DIR_BIT] = dir_ff;
                        nxt_rdata[STAT_DRIVE_LSB +: 8] = drive_ff;
                        nxt_rdata[STAT_SEC_LSB +: 8] = sec_ff;
                    end
                    default: nxt_rresp = RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_ff <= RST_STOP_HOLD;
            bdist_ff <= RST_BRAKE_DIST;
            // Piston-sync builds come out of reset on the complex curve
            cfg_ff <= PISTON_SYNC ? RST_CONFIG_PSYNC : RST_CONFIG;
            bemf_ff <= RST_BEMF;
            act_ff <= RST_ACTION;
            basic_ff <= '{vstart: RST_VSTART, vmid: RST_VMID, vhigh: RST_VHIGH};
            for (int i = 0; i < N_CPLX; i++) begin
                cplx_ff[i] <= 8'(i * RST_CPLX_STEP);
            end
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else begin
            hold_ff <= nxt_hold;
            bdist_ff <= nxt_bdist;
            cfg_ff <= nxt_cfg;
            bemf_ff <= nxt_bemf;
            act_ff <= nxt_act;
            basic_ff <= nxt_basic;
            cplx_ff <= nxt_cplx;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Track pins cross in through two flops each
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            asym_m_ff <= 1'b0;
            asym_s_ff <= 1'b0;
            asym_d_ff <= 1'b0;
            pick_m_ff <= 1'b0;
            pick_s_ff <= 1'b0;
        end else begin
            asym_m_ff <= ASYM_TRACK_CONDITION;
            asym_s_ff <= asym_m_ff;
            asym_d_ff <= asym_s_ff;
            pick_m_ff <= PICKUPS_CLEAR;
            pick_s_ff <= pick_m_ff;
        end
    end
    // Edge, not level: a timed hold that ends inside the section must not retrigger
    assign asym_rise = asym_s_ff && !asym_d_ff;

    asc_tick #(.PERIOD(HOLD_TICK_CYCLES)) u_sec_tick (
        .clk(CLK),
        .rst_b(RST_B),
        .run(st_ff == ST_HOLD),
        .tick(sec_tick)
    );
    asc_tick #(.PERIOD(DECEL_CYCLES)) u_dec_tick (
        .clk(CLK),
        .rst_b(RST_B),
        .run(st_ff == ST_BRAKE),
        .tick(dec_tick)
    );
    asc_tick #(.PERIOD(DIST_CYCLES)) u_dist_tick (
        .clk(CLK),
        .rst_b(RST_B),
        .run((st_ff == ST_BRAKE) && pick_s_ff),
        .tick(dist_tick)
    );
    asc_curve u_curve (
        .step(thr_ff),
        .use_cplx(cfg_ff[CFG_CPLX_BIT]),
        .steam_cap(STEAM_CAP),
        .basic(basic_ff),
        .cplx(cplx_ff),
        .level(curve_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Stop control
    assign dist_tgt = 16'(bdist_ff) << DIST_SHIFT;

    always_comb begin
        nxt_st = st_ff;
        nxt_thr = thr_ff;
        nxt_dir = dir_ff;
        nxt_drive = drive_ff;
        nxt_dist = dist_ff;
        nxt_sec = sec_ff;
        nxt_bemf_en = (bemf_ff == BEMF_FULL) || ({1'b0, thr_ff} <= bemf_ff);
        unique case (st_ff)
            ST_RUN: begin
                if (THR_CMD.valid) begin
                    nxt_thr = THR_CMD.step;
                    nxt_dir = THR_CMD.dir;
                end
                nxt_drive = curve_lvl;
                if (asym_rise) begin
                    nxt_st = ST_BRAKE;
                    nxt_drive = drive_ff;
                    nxt_dist = 16'h0000;
                end
            end
            ST_BRAKE: begin
                if (act_ff[ACT_CBD_BIT]) begin
                    // Hold entry speed over a fixed distance, counted once clear of the break
                    if (pick_s_ff && (dist_ff >= dist_tgt)) begin
                        nxt_st = ST_HOLD;
                        nxt_drive = 8'h00;
                        nxt_sec = hold_ff;
                    end else if (dist_tick) begin
                        nxt_dist = dist_ff + {8'h00, drive_ff};
                    end
                end else if (drive_ff == 8'h00) begin
                    nxt_st = ST_HOLD;
                    nxt_sec = hold_ff;
                end else if (dec_tick) begin
                    nxt_drive = drive_ff - 8'h01;
                end
            end
            ST_HOLD: begin
                nxt_drive = 8'h00;
                if (sec_ff == 8'h00) begin
                    if (!asym_s_ff) nxt_st = ST_RUN;
                end else if (sec_tick) begin
                    nxt_sec = sec_ff - 8'h01;
                    if (sec_ff == 8'h01) nxt_st = ST_RUN;
                end
                if ((nxt_st == ST_RUN) && act_ff[ACT_SHUTTLE_BIT]) nxt_dir = !dir_ff;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_ff <= ST_RUN;
            thr_ff <= 7'h00;
            dir_ff <= 1'b0;
            drive_ff <= 8'h00;
            dist_ff <= 16'h0000;
            sec_ff <= 8'h00;
            bemf_en_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            thr_ff <= nxt_thr;
            dir_ff <= nxt_dir;
            drive_ff <= nxt_drive;
            dist_ff <= nxt_dist;
            sec_ff <= nxt_sec;
            bemf_en_ff <= nxt_bemf_en;
        end
    end

    assign MOTOR_DRIVE = drive_ff;
    assign MOTOR_DIR = dir_ff;
    assign BEMF_ENABLE = bemf_en_ff;
    assign HALTED = (st_ff == ST_HOLD);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_enter_hold;
        st_ff == ST_BRAKE ##1 st_ff == ST_HOLD;
    endsequence

    property p_trigger;
        st_ff == ST_RUN && asym_rise |=> st_ff == ST_BRAKE;
    endproperty
    a_trigger: assert property (p_trigger) else $error("no brake on asym edge");
    property p_halt_zero;
        st_ff == ST_HOLD |-> drive_ff == 8'h00 && HALTED;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("drive while halted");
    property p_hold_load;
        s_enter_hold |-> sec_ff == $past(hold_ff);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("hold not reloaded");
    property p_indef;
        st_ff == ST_HOLD && sec_ff == 8'h00 && asym_s_ff |=> st_ff == ST_HOLD;
    endproperty
    a_indef: assert property (p_indef) else $error("left indefinite halt");
    property p_resume;
        st_ff == ST_HOLD && sec_ff == 8'h00 && !asym_s_ff |=> st_ff == ST_RUN;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after clear");
    property p_cmd_drop;
        st_ff != ST_RUN |=> thr_ff == $past(thr_ff) && (dir_ff == $past(dir_ff)
            || $past(st_ff) == ST_HOLD);
    endproperty
    a_cmd_drop: assert property (p_cmd_drop) else $error("command taken in halt");
    property p_cbd_wait;
        st_ff == ST_BRAKE && act_ff[ACT_CBD_BIT] && !pick_s_ff ##1 st_ff == ST_BRAKE
            |-> dist_ff == $past(dist_ff);
    endproperty
    a_cbd_wait: assert property (p_cbd_wait) else $error("distance before clear");
    property p_bemf;
        bemf_ff == BEMF_FULL |=> BEMF_ENABLE;
    endproperty
    a_bemf: assert property (p_bemf) else $error("bemf off at max cutoff");
    property p_step0;
        st_ff == ST_RUN && thr_ff == 7'h00 && !asym_rise |=> drive_ff == 8'h00;
    endproperty
    a_step0: assert property (p_step0) else $error("drive at step zero");
    property p_bresp;
        wr_go |=> S_AXI_BVALID ##0 S_AXI_BVALID [*1];
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");
endmodule
`default_nettype wire

// ---- shared/asc_pkg.sv ----
`default_nettype none
package asc_pkg;
    // Timing at a 40 ns clock
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned HOLD_TICK_NS = 1_000_000_000;
    localparam int unsigned HOLD_TICK_CYC = HOLD_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned DECEL_STEP_NS = 5_000_000;
    localparam int unsigned DECEL_STEP_CYC = DECEL_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned DIST_TICK_NS = 1_000_000;
    localparam int unsigned DIST_TICK_CYC = DIST_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned DIST_SHIFT = 4;
    localparam int unsigned N_CPLX = 27;
    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_STOP_HOLD = 8'h00;
    localparam logic [7:0] OFS_BRAKE_DIST = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_BEMF = 8'h0C;
    localparam logic [7:0] OFS_ACTION = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_VSTART = 8'h20;
    localparam logic [7:0] OFS_VMID = 8'h24;
    localparam logic [7:0] OFS_VHIGH = 8'h28;
    localparam logic [7:0] OFS_CPLX = 8'h40;
    localparam logic [7:0] OFS_CPLX_END = 8'hAC;
    // Reset values
    localparam logic [7:0] RST_STOP_HOLD = 8'h05;
    localparam logic [7:0] RST_BRAKE_DIST = 8'h19;
    localparam logic [7:0] RST_CONFIG = 8'h02;
    localparam logic [7:0] RST_CONFIG_PSYNC = 8'h12;
    localparam logic [7:0] RST_BEMF = 8'h7F;
    localparam logic [1:0] RST_ACTION = 2'h0;
    localparam logic [7:0] RST_VSTART = 8'h08;
    localparam logic [7:0] RST_VMID = 8'h80;
    localparam logic [7:0] RST_VHIGH = 8'hFF;
    localparam logic [7:0] RST_CPLX_STEP = 8'h09;
    // Fields
    localparam int unsigned CFG_CPLX_BIT = 4;
    localparam int unsigned ACT_CBD_BIT = 0;
    localparam int unsigned ACT_SHUTTLE_BIT = 1;
    localparam logic [7:0] BEMF_FULL = 8'h7F;
    localparam logic [6:0] STEP_MID = 7'h40;
    localparam logic [6:0] STEP_MAX = 7'h7F;
    localparam int unsigned STAT_HALT_BIT = 0;
    localparam int unsigned STAT_BRAKE_BIT = 1;
    localparam int unsigned STAT_BEMF_BIT = 2;
    localparam int unsigned STAT_DIR_BIT = 3;
    localparam int unsigned STAT_DRIVE_LSB = 8;
    localparam int unsigned STAT_SEC_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] vstart;
        logic [7:0] vmid;
        logic [7:0] vhigh;
    } asc_basic_t;
    typedef logic [N_CPLX-1:0][7:0] asc_cplx_t;
    typedef struct packed {
        logic valid;
        logic [6:0] step;
        logic dir;
    } asc_cmd_t;
    typedef enum logic [1:0] {ST_RUN, ST_BRAKE, ST_HOLD} asc_state_t;
endpackage
`default_nettype wire

// ---- sim/asc_station.sv ----
`default_nettype none
module asc_station (
    input wire logic clk,
    output var asc_pkg::asc_cmd_t cmd,
    output var logic asym,
    output var logic pickups
);
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    initial begin
        cmd = '0;
        asym = 1'b0;
        pickups = 1'b0;
    end
    // Payload is scrambled between pulses so nothing can lean on a stale step
    task automatic send(input logic [6:0] step, input logic dir);
        @(posedge clk);
        cmd <= '{1'b1, step, dir};
        @(posedge clk);
        cmd <= '{1'b0, ~step, ~dir};
    endtask
    task automatic track(input logic a, input logic p);
        @(posedge clk);
        asym <= a;
        pickups <= p;
    endtask
endmodule
`default_nettype wire

// ---- sim/asym_stop_speed_curve_tb.sv ----
`default_nettype none
module asym_stop_speed_curve_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    logic clk, rst_b, awv, wv, bready, arv, rready, asym, pick;
    logic awr, wr_rdy, bv, arr, rv, halted, mdir, bemf;
    logic [7:0] awaddr, araddr, drive;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    asc_cmd_t thr;
    int err_count = 0;
    int comparisons = 0;
    asc_top #(.HOLD_TICK_CYCLES(20), .DECEL_CYCLES(4), .DIST_CYCLES(4)) dut (
        .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .THR_CMD(thr),
        .ASYM_TRACK_CONDITION(asym), .PICKUPS_CLEAR(pick), .MOTOR_DRIVE(drive),
        .MOTOR_DIR(mdir), .BEMF_ENABLE(bemf), .HALTED(halted));
    asc_station st (.clk(clk), .cmd(thr), .asym(asym), .pickups(pick));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int i, input int n);
        if (i >= n) begin
            err_count++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        i = 0;
        do begin @(negedge clk); i++; end while (awr !== 1'b1 && i < 60);
        wt(i, 60);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        i = 0;
        while (bv !== 1'b1 && i < 60) begin @(negedge clk); i++; end
        wt(i, 60);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        int i;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        i = 0;
        do begin @(negedge clk); i++; end while (arr !== 1'b1 && i < 60);
        wt(i, 60);
        @(posedge clk);
        arv <= 1'b0;
        i = 0;
        while (rv !== 1'b1 && i < 60) begin @(negedge clk); i++; end
        wt(i, 60);
        chk({30'h0, rresp}, {30'h0, er});
        if (er === RESP_OKAY) chk(rdata, {24'h0, e});
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic wait_halt(input logic v, input int n);
        int i;
        i = 0;
        while (halted !== v && i < n) begin @(negedge clk); i++; end
        wt(i, n);
    endtask
    task automatic drv(input logic [6:0] s, input logic [7:0] e);
        st.send(s, 1'b0);
        repeat (5) @(negedge clk);
        chk({24'h0, drive}, {24'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, awv, wv, bready, arv, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'h1;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFS_STOP_HOLD, RST_STOP_HOLD, RESP_OKAY);
        rd(OFS_BRAKE_DIST, RST_BRAKE_DIST, RESP_OKAY);
        rd(OFS_CONFIG, RST_CONFIG, RESP_OKAY);
        rd(OFS_BEMF, RST_BEMF, RESP_OKAY);
        rd(OFS_CPLX + 8'h68, 8'hEA, RESP_OKAY);
        rd(8'h18, 8'h00, RESP_SLVERR);
        $display("test registers done");
        drv(7'h7F, RST_VHIGH);
        chk({31'h0, bemf}, 32'h1);
        wr(OFS_CONFIG, 8'h12, RESP_OKAY);
        drv(7'h7F, 8'hEA);
        wr(OFS_CPLX + 8'h68, 8'h33, RESP_OKAY);
        drv(7'h7F, 8'h33);
        drv(7'h00, 8'h00);
        wr(OFS_CONFIG, RST_CONFIG, RESP_OKAY);
        wr(OFS_BEMF, 8'h10, RESP_OKAY);
        drv(7'h7F, RST_VHIGH);
        chk({31'h0, bemf}, 32'h0);
        wr(OFS_BEMF, RST_BEMF, RESP_OKAY);
        $display("test curves done");
        wr(OFS_STOP_HOLD, 8'h02, RESP_OKAY);
        drv(7'h7F, RST_VHIGH);
        st.track(1'b1, 1'b0);
        wait_halt(1'b1, 1400);
        chk({24'h0, drive}, 32'h0);
        st.send(7'h7F, 1'b1);
        repeat (25) @(negedge clk);
        chk({31'h0, mdir}, 32'h0);
        chk({31'h0, halted}, 32'h1);
        wait_halt(1'b0, 20);
        st.track(1'b0, 1'b0);
        $display("test timed hold done");
        wr(OFS_STOP_HOLD, 8'h00, RESP_OKAY);
        wr(OFS_ACTION, 8'h03, RESP_OKAY);
        wr(OFS_BRAKE_DIST, 8'h01, RESP_OKAY);
        drv(7'h7F, RST_VHIGH);
        st.track(1'b1, 1'b0);
        repeat (30) @(negedge clk);
        chk({23'h0, halted, drive}, {24'h0, RST_VHIGH});
        st.track(1'b1, 1'b1);
        wait_halt(1'b1, 40);
        repeat (100) @(negedge clk);
        chk({31'h0, halted}, 32'h1);
        rd(OFS_STATUS, 8'h05, RESP_OKAY);
        st.track(1'b0, 1'b1);
        wait_halt(1'b0, 10);
        drv(7'h7F, RST_VHIGH);
        st.track(1'b1, 1'b1);
        wait_halt(1'b1, 40);
        st.track(1'b0, 1'b1);
        wait_halt(1'b0, 10);
        chk({31'h0, mdir}, 32'h1);
        $display("test permanent halt done");
        report_and_stop();
    end
endmodule
`default_nettype wire
